// File: hdl/velocity_bank_defines.vh
// Purpose: constants of the velocity object bank
// Assumes: 16-bit drive registers, object index/subindex addressing
// Notes: definitions only
`ifndef VELOCITY_BANK_DEFINES_VH
`define VELOCITY_BANK_DEFINES_VH

// object indices and subindices
`define OBJ_INFO 16'h4001
`define SUB_BOOT_REV 8'h01
`define SUB_APP_REV 8'h02
`define SUB_UPTIME 8'h03
`define SUB_ACTIVE_ERR 8'h04
`define SUB_STICKY_ERR 8'h05
`define OBJ_CONTROL 16'h6040
`define OBJ_STATE 16'h6041
`define OBJ_TARGET 16'h6042
`define OBJ_DEMAND 16'h6043
`define OBJ_ACTUAL 16'h6044
`define OBJ_LIMITS 16'h6046
`define SUB_LIMIT_MIN 8'h01
`define SUB_LIMIT_MAX 8'h02
`define SUB_ZERO 8'h00

// drive register space addresses
`define DRV_RUN_CMD 16'h0001
`define DRV_REF_FREQ 16'h0010
`define DRV_OUT_FREQ 16'h003E
`define DRV_MOTOR_SPEED 16'h00AC
`define DRV_STATUS 16'h00FC
`define DRV_DISPLAY_UNIT 16'h0502
`define DRV_POLE_COUNT 16'h0211
`define DRV_MAX_FREQ 16'h0303
`define DRV_UPPER_LIMIT 16'h0289
`define DRV_LOWER_LIMIT 16'h028A

// drive field values
`define REVERSE_MASK 16'h0004
`define DISPLAY_RPM 16'h0002
`define RUN_STOP 16'h0000
`define RUN_FWD 16'h0001
`define RUN_REV 16'h0002
`define REF_MAX 16'h7FFF

// control word decoding and state word codes
`define CW_FAULT_RESET 7
`define CW_MASK_SHUTDOWN 16'h0087
`define CW_SHUTDOWN 16'h0006
`define CW_MASK_SWITCH 16'h008F
`define CW_SWITCH_ON 16'h0007
`define CW_OPERATION_ENABLED_COMMAND 16'h000F
`define CW_MASK_VOLTAGE 16'h0082
`define CW_DISABLE_VOLT 16'h0000
`define SW_DISABLED 16'h0040
`define SW_READY 16'h0021
`define SW_SWITCHED_ON 16'h0023
`define SW_OP_ENABLED 16'h0027
`define SW_FAULT 16'h0008

// conversion: percent in 0.1 % = rpm*poles*1000 / (12 * maxFreq[0.1 Hz])
`define PCT_SCALE 48'h0000000003E8
`define FULL_SCALE_MUL 32'h0000000C

// timing
`define CLOCK_HZ 25000000
`define MS_PER_S 1000
`define DIV_STEPS 6'h30

`endif

// File: hdl/round_divider.v
// Purpose: unsigned divider rounding to nearest
// Assumes: start only while idle; den of zero gives all ones
// Notes: one quotient bit per clock, 48 steps
`timescale 1ns/1ns
`include "velocity_bank_defines.vh"

module round_divider (
    input wire clock,
    input wire rst,
    input wire start,
    input wire [47:0] num,
    input wire [31:0] den,
    output reg busy,
    output reg done,
    output reg [47:0] quo
);
    reg [47:0] shiftQ;
    reg [32:0] rem;
    reg [31:0] divisor;
    reg [5:0] steps;
    wire [32:0] trial;

    assign trial = {rem[31:0], shiftQ[47]};

    always @(posedge clock)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
            quo <= 48'h0;
            shiftQ <= 48'h0;
            rem <= 33'h0;
            divisor <= 32'h0;
            steps <= 6'h0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                // adding half the divisor first turns truncation into rounding
                shiftQ <= num + {17'h0, den[31:1]};
                divisor <= den;
                rem <= 33'h0;
                steps <= `DIV_STEPS;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (trial >= {1'b0, divisor})
                begin
                    rem <= trial - {1'b0, divisor};
                    shiftQ <= {shiftQ[46:0], 1'b1};
                end
                else
                begin
                    rem <= trial;
                    shiftQ <= {shiftQ[46:0], 1'b0};
                end
                steps <= steps - 6'h1;
                if (steps == 6'h1)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    if (trial >= {1'b0, divisor})
                        quo <= {shiftQ[46:0], 1'b1};
                    else
                        quo <= {shiftQ[46:0], 1'b0};
                end
            end
        end
    end
endmodule // round_divider

// File: hdl/velocity_object_bank.v
// Purpose: option info and velocity-mode objects of a drive option card
// Assumes: object port answers one cycle after a request; drive register
//          port holds drvReq until drvAck
// Notes: drive registers are polled into a small cache between writes
`timescale 1ns/1ns
`include "velocity_bank_defines.vh"

module velocity_object_bank #(
    parameter [31:0] BOOT_REVISION = 32'h00010203,
    parameter [31:0] APP_REVISION = 32'h00040506,
    parameter MS_CYCLES = `CLOCK_HZ / `MS_PER_S
) (
    input wire clock,
    input wire rst,
    input wire objReq,
    input wire objWrite,
    input wire [15:0] objIndex,
    input wire [7:0] objSub,
    input wire [31:0] objWdata,
    output reg objAck,
    output reg objAbort,
    output reg [31:0] objRdata,
    input wire [15:0] dimFactor,
    input wire [15:0] activeErrorIn,
    input wire driveFault,
    output reg drvReq,
    output reg drvWrite,
    output reg [15:0] drvAddr,
    output reg [15:0] drvWdata,
    input wire [15:0] drvRdata,
    input wire drvAck
);
    // control states
    localparam [2:0] ST_DISABLED = 3'h0;
    localparam [2:0] ST_READY = 3'h1;
    localparam [2:0] ST_SWITCHED = 3'h2;
    localparam [2:0] ST_OP_EN = 3'h3;
    localparam [2:0] ST_FAULT = 3'h4;
    // drive port states
    localparam [1:0] D_IDLE = 2'h0;
    localparam [1:0] D_ACC = 2'h1;
    localparam [1:0] D_DIV = 2'h2;
    // kind of drive access in flight
    localparam [1:0] K_POLL = 2'h0;
    localparam [1:0] K_RUN = 2'h1;
    localparam [1:0] K_REF = 2'h2;
    localparam [1:0] K_LIMIT = 2'h3;
    localparam [2:0] POLL_LAST = 3'h5;
    // arbitrary revisions above; the top byte is always forced to zero

    reg [31:0] uptime;
    reg [31:0] msCount;
    reg [15:0] stickyErrors;
    reg [15:0] controlWord;
    reg [2:0] state;
    reg [15:0] targetVelocity;
    reg [15:0] refMag;
    reg revDir;
    reg [31:0] limitMin;
    reg [31:0] limitMax;
    reg pendLo;
    reg pendHi;
    reg workLo;
    reg [15:0] lastRun;
    reg [15:0] lastRef;
    reg [1:0] dstate;
    reg [1:0] accKind;
    reg [2:0] pollIdx;
    reg divStart;
    reg [15:0] stateWord;
    reg [15:0] runWord;
    reg [15:0] pollAddr;
    reg [15:0] rpmSat;

    wire [15:0] cache [0:5];
    wire unitOk;
    wire isVelocity;
    wire reverse;
    wire [15:0] demand;
    wire [15:0] actual;
    wire signed [31:0] scaled;
    wire [31:0] scaledMag;
    wire [47:0] divNum;
    wire [31:0] divDen;
    wire divDone;
    wire [47:0] divQuo;
    wire limitsReady;

    // drive register cache, one entry per polled address
    genvar gi;
    generate
        for (gi = 0; gi <= 5; gi = gi + 1)
        begin : cacheEntry
            reg [15:0] value;
            always @(posedge clock)
            begin
                if (rst)
                    value <= 16'h0;
                else if (dstate == D_ACC && accKind == K_POLL && drvAck
                         && pollIdx == gi)
                    value <= drvRdata;
            end
            assign cache[gi] = value;
        end
    endgenerate

    // cache order: status, output freq, motor speed, unit, poles, max freq
    always @*
    begin
        case (pollIdx)
            3'h0: pollAddr = `DRV_STATUS;
            3'h1: pollAddr = `DRV_OUT_FREQ;
            3'h2: pollAddr = `DRV_MOTOR_SPEED;
            3'h3: pollAddr = `DRV_DISPLAY_UNIT;
            3'h4: pollAddr = `DRV_POLE_COUNT;
            default: pollAddr = `DRV_MAX_FREQ;
        endcase
    end

    assign unitOk = cache[3] == `DISPLAY_RPM;
    assign isVelocity = objIndex[15:4] == `OBJ_CONTROL >> 4;

    assign reverse = (cache[0] & `REVERSE_MASK) != 16'h0;
    assign demand = reverse ? 16'h0 - cache[1] : cache[1];
    assign actual = reverse ? 16'h0 - cache[2] : cache[2];

    assign scaled = $signed(objWdata[15:0]) * $signed(dimFactor);
    assign scaledMag = scaled[31] ? 32'h0 - scaled : scaled;

    // rounded percent of full scale; poles must be set beforehand
    assign divNum = {32'h0, rpmSat} * {32'h0, cache[4]} * `PCT_SCALE;
    assign divDen = {16'h0, cache[5]} * `FULL_SCALE_MUL;
    // no limit conversion until poles and max frequency are known
    assign limitsReady = cache[4] != 16'h0 && cache[5] != 16'h0;

    always @*
    begin
        if (workLo)
            rpmSat = limitMin[31:16] != 16'h0 ? 16'hFFFF : limitMin[15:0];
        else
            rpmSat = limitMax[31:16] != 16'h0 ? 16'hFFFF : limitMax[15:0];
    end

    always @*
    begin
        case (state)
            ST_READY: stateWord = `SW_READY;
            ST_SWITCHED: stateWord = `SW_SWITCHED_ON;
            ST_OP_EN: stateWord = `SW_OP_ENABLED;
            ST_FAULT: stateWord = `SW_FAULT;
            default: stateWord = `SW_DISABLED;
        endcase
    end

    always @*
    begin
        if (state != ST_OP_EN)
            runWord = `RUN_STOP;
        else if (revDir)
            runWord = `RUN_REV;
        else
            runWord = `RUN_FWD;
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            msCount <= 32'h0;
            uptime <= 32'h0;
        end
        else if (msCount == MS_CYCLES - 1)
        begin
            msCount <= 32'h0;
            uptime <= uptime + 32'h1;
        end
        else
            msCount <= msCount + 32'h1;
    end

    // sticky errors never clear before reset
    always @(posedge clock)
    begin
        if (rst)
            stickyErrors <= 16'h0;
        else
            stickyErrors <= stickyErrors | activeErrorIn;
    end

    // object port: answer and register writes
    always @(posedge clock)
    begin
        if (rst)
        begin
            objAck <= 1'b0;
            objAbort <= 1'b0;
            objRdata <= 32'h0;
            controlWord <= 16'h0;
            state <= ST_DISABLED;
            targetVelocity <= 16'h0;
            refMag <= 16'h0;
            revDir <= 1'b0;
            limitMin <= 32'h0;
            limitMax <= 32'h0;
            pendLo <= 1'b0;
            pendHi <= 1'b0;
        end
        else
        begin
            objAck <= 1'b0;
            objAbort <= 1'b0;
            if (driveFault)
                state <= ST_FAULT;
            // a new write wins over the clear at divider start
            if (divStart && workLo)
                pendLo <= 1'b0;
            if (divStart && !workLo)
                pendHi <= 1'b0;
            if (objReq)
            begin
                objAck <= 1'b1;
                objRdata <= 32'h0;
                if (isVelocity && !unitOk)
                    objAbort <= 1'b1;
                else if (objIndex == `OBJ_INFO && !objWrite)
                begin
                    if (objSub == `SUB_BOOT_REV)
                        objRdata <= {8'h0, BOOT_REVISION[23:0]};
                    else if (objSub == `SUB_APP_REV)
                        objRdata <= {8'h0, APP_REVISION[23:0]};
                    else if (objSub == `SUB_UPTIME)
                        objRdata <= uptime;
                    else if (objSub == `SUB_ACTIVE_ERR)
                        objRdata <= {16'h0, activeErrorIn};
                    else if (objSub == `SUB_STICKY_ERR)
                        objRdata <= {16'h0, stickyErrors};
                    else
                        objAbort <= 1'b1;
                end
                else if (objIndex == `OBJ_CONTROL && objSub == `SUB_ZERO)
                begin
                    objRdata <= {16'h0, controlWord};
                    if (objWrite)
                    begin
                        controlWord <= objWdata[15:0];
                        if (state == ST_FAULT)
                        begin
                            if (objWdata[`CW_FAULT_RESET] && !driveFault)
                                state <= ST_DISABLED;
                        end
                        else if ((objWdata[15:0] & `CW_MASK_VOLTAGE)
                                 == `CW_DISABLE_VOLT)
                            state <= ST_DISABLED;
                        else if ((objWdata[15:0] & `CW_MASK_SHUTDOWN)
                                 == `CW_SHUTDOWN)
                            state <= ST_READY;
                        else if ((objWdata[15:0] & `CW_MASK_SWITCH)
                                 == `CW_SWITCH_ON && state != ST_DISABLED)
                            state <= ST_SWITCHED;
                        else if ((objWdata[15:0] & `CW_MASK_SWITCH)
                                 == `CW_OPERATION_ENABLED_COMMAND && state != ST_DISABLED)
                            state <= ST_OP_EN;
                    end
                end
                else if (objIndex == `OBJ_STATE && objSub == `SUB_ZERO
                         && !objWrite)
                    objRdata <= {16'h0, stateWord};
                else if (objIndex == `OBJ_TARGET && objSub == `SUB_ZERO)
                begin
                    objRdata <= {{16{targetVelocity[15]}}, targetVelocity};
                    if (objWrite)
                    begin
                        if (state != ST_OP_EN)
                            objAbort <= 1'b1;
                        else
                        begin
                            targetVelocity <= objWdata[15:0];
                            revDir <= scaled[31];
                            // saturate rather than wrap the reference
                            if (scaledMag > {16'h0, `REF_MAX})
                                refMag <= `REF_MAX;
                            else
                                refMag <= scaledMag[15:0];
                        end
                    end
                end
                else if (objIndex == `OBJ_DEMAND && objSub == `SUB_ZERO
                         && !objWrite)
                    objRdata <= {{16{demand[15]}}, demand};
                else if (objIndex == `OBJ_ACTUAL && objSub == `SUB_ZERO
                         && !objWrite)
                    objRdata <= {{16{actual[15]}}, actual};
                else if (objIndex == `OBJ_LIMITS
                         && objSub == `SUB_LIMIT_MIN)
                begin
                    objRdata <= limitMin;
                    if (objWrite)
                    begin
                        limitMin <= objWdata;
                        pendLo <= 1'b1;
                    end
                end
                else if (objIndex == `OBJ_LIMITS
                         && objSub == `SUB_LIMIT_MAX)
                begin
                    objRdata <= limitMax;
                    if (objWrite)
                    begin
                        limitMax <= objWdata;
                        pendHi <= 1'b1;
                    end
                end
                else
                    objAbort <= 1'b1;
            end
        end
    end

    // drive register port: run/reference writes first, then limits, else poll
    always @(posedge clock)
    begin
        if (rst)
        begin
            dstate <= D_IDLE;
            accKind <= K_POLL;
            pollIdx <= 3'h0;
            drvReq <= 1'b0;
            drvWrite <= 1'b0;
            drvAddr <= 16'h0;
            drvWdata <= 16'h0;
            lastRun <= `RUN_STOP;
            lastRef <= 16'h0;
            workLo <= 1'b0;
            divStart <= 1'b0;
        end
        else
        begin
            divStart <= 1'b0;
            case (dstate)
                D_IDLE:
                begin
                    dstate <= D_ACC;
                    drvReq <= 1'b1;
                    if (refMag != lastRef)
                    begin
                        accKind <= K_REF;
                        drvWrite <= 1'b1;
                        drvAddr <= `DRV_REF_FREQ;
                        drvWdata <= refMag;
                    end
                    else if (runWord != lastRun)
                    begin
                        accKind <= K_RUN;
                        drvWrite <= 1'b1;
                        drvAddr <= `DRV_RUN_CMD;
                        drvWdata <= runWord;
                    end
                    else if ((pendLo || pendHi) && limitsReady)
                    begin
                        dstate <= D_DIV;
                        drvReq <= 1'b0;
                        workLo <= pendLo;
                        divStart <= 1'b1;
                    end
                    else
                    begin
                        accKind <= K_POLL;
                        drvWrite <= 1'b0;
                        drvAddr <= pollAddr;
                    end
                end
                D_DIV:
                begin
                    if (divDone)
                    begin
                        dstate <= D_ACC;
                        accKind <= K_LIMIT;
                        drvReq <= 1'b1;
                        drvWrite <= 1'b1;
                        drvAddr <= workLo ? `DRV_LOWER_LIMIT
                                          : `DRV_UPPER_LIMIT;
                        drvWdata <= divQuo[47:16] != 32'h0 ? 16'hFFFF
                                                           : divQuo[15:0];
                    end
                end
                default:
                begin
                    if (drvAck)
                    begin
                        dstate <= D_IDLE;
                        drvReq <= 1'b0;
                        drvWrite <= 1'b0;
                        if (accKind == K_RUN)
                            lastRun <= drvWdata;
                        if (accKind == K_REF)
                            lastRef <= drvWdata;
                        if (accKind == K_POLL)
                            pollIdx <= pollIdx == POLL_LAST ? 3'h0
                                                            : pollIdx + 3'h1;
                    end
                end
            endcase
        end
    end

    round_divider limitDivider (
        .clock(clock),
        .rst(rst),
        .start(divStart),
        .num(divNum),
        .den(divDen),
        .busy(),
        .done(divDone),
        .quo(divQuo)
    );
endmodule // velocity_object_bank

// File: sim/velocity_bank_chk.sv
// Purpose: port assertions of the velocity object bank
// Assumes: one clock, rst synchronous active high
// Notes: bound to the design top, watches port signals only, inputs and outputs
`timescale 1ns/1ns
module velocity_bank_chk #(
    parameter [31:0] BOOT_REVISION = 32'h00000000,
    parameter [31:0] APP_REVISION = 32'h00000000
) (
    input wire clock,
    input wire rst,
    input wire objReq,
    input wire objWrite,
    input wire [15:0] objIndex,
    input wire [7:0] objSub,
    input wire objAck,
    input wire objAbort,
    input wire [31:0] objRdata,
    input wire [15:0] activeErrorIn,
    input wire drvReq,
    input wire drvAck,
    input wire [15:0] drvAddr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire infoRd = objReq && !objWrite && objIndex == 16'h4001;
    sequence drv_wait; drvReq && !drvAck; endsequence
    sequence drv_hold; drvReq && $stable(drvAddr); endsequence
    boot_rev_a: assert property (infoRd && objSub == 8'h01 |=>
        objAck && !objAbort && objRdata == {8'h00, BOOT_REVISION[23:0]})
        else $error("boot");
    app_rev_a: assert property (infoRd && objSub == 8'h02 |=>
        objAck && !objAbort && objRdata == {8'h00, APP_REVISION[23:0]})
        else $error("app");
    active_err_a: assert property (infoRd && objSub == 8'h04 |=>
        objRdata == {16'h0000, $past(activeErrorIn)}) else $error("active");
    sticky_keep_a: assert property (infoRd && objSub == 8'h05
        && $stable(activeErrorIn) |=> (objRdata[15:0] & $past(activeErrorIn))
        == $past(activeErrorIn)) else $error("sticky lost");
    info_ro_a: assert property (objReq && objWrite
        && objIndex == 16'h4001 |=> objAbort) else $error("info written");
    state_ro_a: assert property (objReq && objWrite
        && objIndex == 16'h6041 |=> objAbort) else $error("state written");
    ack_follow_a: assert property (objReq |=> objAck) else $error("no ack");
    ack_only_a: assert property (objAck |-> $past(objReq)) else $error("ack");
    drv_stable_a: assert property (drv_wait |=> drv_hold) else $error("drop");
    drv_gap_a: assert property (drvReq && drvAck |=> !drvReq) else $error("gap");
endmodule // velocity_bank_chk

bind velocity_object_bank velocity_bank_chk #(.BOOT_REVISION(BOOT_REVISION),
    .APP_REVISION(APP_REVISION)) u_chk (.clock(clock), .rst(rst),
    .objReq(objReq), .objWrite(objWrite), .objIndex(objIndex),
    .objSub(objSub), .objAck(objAck), .objAbort(objAbort),
    .objRdata(objRdata), .activeErrorIn(activeErrorIn), .drvReq(drvReq),
    .drvAck(drvAck), .drvAddr(drvAddr));

// File: sim/drive_regs_model.sv
// Purpose: behavioural drive register space
// Assumes: one access at a time, held until drvAck
// Notes: latency alternates prompt and slow; idle read data toggles
`timescale 1ns/1ns
module drive_regs_model (
    input wire clock,
    input wire drvReq,
    input wire drvWrite,
    input wire [15:0] drvAddr,
    input wire [15:0] drvWdata,
    output reg [15:0] drvRdata,
    output reg drvAck
);
    reg [15:0] regs [0:65535];
    reg [1:0] waitN = 2'h0;
    reg slow = 1'b0;
    initial drvAck = 1'b0;
    initial drvRdata = 16'h0000;
    always @(posedge clock)
    begin
        drvAck <= 1'b0;
        drvRdata <= ~drvRdata;
        if (drvReq && !drvAck && waitN != 2'h0)
            waitN <= waitN - 2'h1;
        else if (drvReq && !drvAck)
        begin
            drvAck <= 1'b1;
            slow <= ~slow;
            waitN <= slow ? 2'h0 : 2'h2;
            if (drvWrite)
                regs[drvAddr] <= drvWdata;
            else
                drvRdata <= regs[drvAddr];
        end
    end
endmodule // drive_regs_model

// File: sim/tb.sv
// Purpose: self-checking bench of the velocity object bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: ms count shortened to 10 cycles
`timescale 1ns/1ns
`define CHK(got, exp) begin testsRun = testsRun + 1; \
    if ((got) !== (exp)) begin errTotal = errTotal + 1; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
    localparam [31:0] BOOT = 32'h00A1B2C3; // arbitrary value
    localparam [31:0] APP = 32'h00D4E5F6; // arbitrary value
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg objReq = 1'b0;
    reg objWrite = 1'b0;
    reg [15:0] objIndex = 16'h0000;
    reg [7:0] objSub = 8'h00;
    reg [31:0] objWdata = 32'h00000000;
    reg [15:0] dimFactor = 16'h0001;
    reg [15:0] activeErrorIn = 16'h0000;
    reg driveFault = 1'b0;
    wire objAck, objAbort, drvReq, drvWrite, drvAck;
    wire [31:0] objRdata;
    wire [15:0] drvAddr, drvWdata, drvRdata;
    reg [31:0] rd, first;
    reg ab;
    integer errTotal = 0;
    integer testsRun = 0;
    integer cycles = 0;
    velocity_object_bank #(.BOOT_REVISION(BOOT), .APP_REVISION(APP),
        .MS_CYCLES(10)) u_dut (.clock(clock), .rst(rst), .objReq(objReq),
        .objWrite(objWrite), .objIndex(objIndex), .objSub(objSub),
        .objWdata(objWdata), .objAck(objAck), .objAbort(objAbort),
        .objRdata(objRdata), .dimFactor(dimFactor),
        .activeErrorIn(activeErrorIn), .driveFault(driveFault),
        .drvReq(drvReq), .drvWrite(drvWrite), .drvAddr(drvAddr),
        .drvWdata(drvWdata), .drvRdata(drvRdata), .drvAck(drvAck));
    drive_regs_model u_drv (.clock(clock), .drvReq(drvReq),
        .drvWrite(drvWrite), .drvAddr(drvAddr), .drvWdata(drvWdata),
        .drvRdata(drvRdata), .drvAck(drvAck));
    always #20 clock = ~clock;
    task closeOut;
        begin
            $display("compared %0d, mismatches %0d", testsRun, errTotal);
            if (errTotal == 0 && testsRun > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // hang guard, whole run needs about 2400 cycles
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errTotal = errTotal + 1;
            closeOut;
        end
    end
    task idle(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    // answer is registered, so it is settled 1 ns after the next edge
    task obj(input w, input [15:0] idx, input [7:0] sub, input [31:0] wd);
        begin
            @(posedge clock);
            #1 objReq = 1'b1;
            objWrite = w;
            objIndex = idx;
            objSub = sub;
            objWdata = wd;
            idle(1);
            objReq = 1'b0;
            rd = objRdata;
            ab = objAbort;
        end
    endtask
    task rdChk(input [15:0] idx, input [7:0] sub, input [31:0] e);
        begin
            obj(1'b0, idx, sub, 32'h00000000);
            `CHK({ab, rd}, {1'b0, e})
        end
    endtask
    task wrChk(input [15:0] idx, input [7:0] sub, input [31:0] wd, input e);
        begin
            obj(1'b1, idx, sub, wd);
            `CHK(ab, e)
        end
    endtask
    initial
    begin
        u_drv.regs[16'h0502] = 16'h0000;
        u_drv.regs[16'h00FC] = 16'h0000;
        u_drv.regs[16'h003E] = 16'h05DC;
        u_drv.regs[16'h00AC] = 16'h05D2;
        u_drv.regs[16'h0303] = 16'h0258;
        u_drv.regs[16'h0211] = 16'h0004;
        idle(5);
        rst = 1'b0;
        idle(50);
        rdChk(16'h4001, 8'h01, BOOT);
        rdChk(16'h4001, 8'h02, APP);
        wrChk(16'h4001, 8'h01, 32'h00000001, 1'b1);
        wrChk(16'h4002, 8'h00, 32'h00000001, 1'b1);
        wrChk(16'h6046, 8'h01, 32'h00000001, 1'b1);
        obj(1'b0, 16'h4001, 8'h03, 32'h00000000);
        first = rd;
        idle(98);
        obj(1'b0, 16'h4001, 8'h03, 32'h00000000);
        `CHK(rd - first, 32'h0000000A)
        activeErrorIn = 16'h00A5;
        idle(2);
        rdChk(16'h4001, 8'h04, 32'h000000A5);
        activeErrorIn = 16'h0100;
        idle(2);
        rdChk(16'h4001, 8'h05, 32'h000001A5);
        rdChk(16'h4001, 8'h04, 32'h00000100);
        activeErrorIn = 16'h0000;
        idle(2);
        rdChk(16'h4001, 8'h05, 32'h000001A5);
        rdChk(16'h4001, 8'h04, 32'h00000000);
        $display("test info done");
        wrChk(16'h6040, 8'h00, 32'h00000006, 1'b1);
        u_drv.regs[16'h0502] = 16'h0002;
        idle(300);
        wrChk(16'h6040, 8'h00, 32'h00000006, 1'b0);
        rdChk(16'h6041, 8'h00, 32'h00000021);
        wrChk(16'h6042, 8'h00, 32'h00000032, 1'b1);
        wrChk(16'h6041, 8'h00, 32'h00000000, 1'b1);
        wrChk(16'h6040, 8'h00, 32'h00000007, 1'b0);
        rdChk(16'h6041, 8'h00, 32'h00000023);
        wrChk(16'h6040, 8'h00, 32'h0000000F, 1'b0);
        rdChk(16'h6041, 8'h00, 32'h00000027);
        rdChk(16'h6040, 8'h00, 32'h0000000F);
        $display("test control done");
        dimFactor = 16'h0002;
        wrChk(16'h6042, 8'h00, 32'h0000FF9C, 1'b0);
        rdChk(16'h6042, 8'h00, 32'hFFFFFF9C);
        idle(300);
        `CHK(u_drv.regs[16'h0010], 16'h00C8)
        `CHK(u_drv.regs[16'h0001], 16'h0002)
        wrChk(16'h6042, 8'h00, 32'h00000032, 1'b0);
        idle(300);
        `CHK(u_drv.regs[16'h0010], 16'h0064)
        `CHK(u_drv.regs[16'h0001], 16'h0001)
        u_drv.regs[16'h00FC] = 16'h0004;
        idle(300);
        rdChk(16'h6043, 8'h00, 32'hFFFFFA24);
        rdChk(16'h6044, 8'h00, 32'hFFFFFA2E);
        u_drv.regs[16'h00FC] = 16'h0000;
        idle(300);
        rdChk(16'h6043, 8'h00, 32'h000005DC);
        rdChk(16'h6044, 8'h00, 32'h000005D2);
        $display("test velocity done");
        wrChk(16'h6046, 8'h01, 32'h00000385, 1'b0);
        wrChk(16'h6046, 8'h02, 32'h00000707, 1'b0);
        idle(400);
        `CHK(u_drv.regs[16'h028A], 16'h01F5)
        `CHK(u_drv.regs[16'h0289], 16'h03E7)
        $display("test limits done");
        driveFault = 1'b1;
        idle(2);
        rdChk(16'h6041, 8'h00, 32'h00000008);
        wrChk(16'h6040, 8'h00, 32'h00000080, 1'b0);
        rdChk(16'h6041, 8'h00, 32'h00000008);
        driveFault = 1'b0;
        idle(2);
        wrChk(16'h6040, 8'h00, 32'h00000080, 1'b0);
        rdChk(16'h6041, 8'h00, 32'h00000040);
        wrChk(16'h6042, 8'h00, 32'h00000032, 1'b1);
        idle(300);
        `CHK(u_drv.regs[16'h0001], 16'h0000)
        $display("test fault done");
        closeOut;
    end
endmodule // tb
